// [test/fn_status_assertions.sv]
`timescale 1ns/1ps
module fn_status_assertions
    import fstat_pkg::*;
#(
    parameter variant_e VARIANT = VARIANT_COMBO
)
(
    // Clock and reset
    input wire logic              clk_i,
    input wire logic              srst_i,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic              reg_rd_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    // Status sources
    input wire logic [1:0]        strap_pin_i,
    input wire logic [1:0]        cfg_aux_en_i,
    input wire power_state_e      cfg_power_state0_i,
    input wire power_state_e      cfg_power_state1_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Sources must hold across the sampling edge, else the one-cycle lag makes the expectation ambiguous.
    sequence rd_s;
        reg_rd_i && reg_addr_i == STATUS_OFFSET && !$past(srst_i) && $stable(cfg_aux_en_i)
            && $stable(cfg_power_state0_i) && $stable(cfg_power_state1_i);
    endsequence
    AST_AUX0: assert property (rd_s |=> reg_rdata_o[3] == $past(cfg_aux_en_i[0]))
        else $error("aux0 shadow wrong");
    AST_AUX1: assert property (rd_s |=> reg_rdata_o[9] == (VARIANT == VARIANT_SINGLE ? 1'b0
        : $past(cfg_aux_en_i[1]))) else $error("aux1 shadow wrong");
    AST_PS0: assert property (rd_s |=> reg_rdata_o[1:0] == $past(cfg_power_state0_i))
        else $error("power state 0 wrong");
    AST_PS1: assert property (rd_s |=> reg_rdata_o[7:6] == (VARIANT == VARIANT_SINGLE ? device_reset_state
        : $past(cfg_power_state1_i))) else $error("power state 1 wrong");
    AST_STRAP1: assert property (($stable(strap_pin_i) [*4]) ##0 (reg_rd_i && reg_addr_i == STATUS_OFFSET)
        |=> reg_rdata_o[8] == (VARIANT == VARIANT_SINGLE ? 1'b0 : $past(strap_pin_i[1])))
        else $error("port1 present wrong");
    AST_EN0: assert property (reg_rdata_o[4] |-> reg_rdata_o[2])
        else $error("port0 enabled without present");
    AST_EN1: assert property (reg_rdata_o[10] |-> reg_rdata_o[8])
        else $error("port1 enabled without present");
    AST_RSVD: assert property ($past(reg_rd_i) && $past(reg_addr_i) == STATUS_OFFSET
        |-> reg_rdata_o[5] == 1'b0 && reg_rdata_o[31:11] == '0) else $error("reserved bits set");
    AST_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == '0)
        else $error("read data outside read cycle");
    AST_UNMAP: assert property (reg_rd_i && reg_addr_i > CTRL_OFFSET |=> reg_rdata_o == '0)
        else $error("unmapped read not zero");
    COV_EN1: cover property (rd_s ##1 reg_rdata_o[10]);
    COV_EN0: cover property (rd_s ##1 reg_rdata_o[4]);
    COV_UNMAP: cover property (reg_rd_i && reg_addr_i > CTRL_OFFSET);
endmodule : fn_status_assertions

bind function_enable_power_status fn_status_assertions #(.VARIANT(VARIANT)) u_chk (.clk_i(clk_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .strap_pin_i(strap_pin_i),
    .cfg_aux_en_i(cfg_aux_en_i), .cfg_power_state0_i(cfg_power_state0_i),
    .cfg_power_state1_i(cfg_power_state1_i));

// [test/test_function_enable_power_status.sv]
`timescale 1ns/1ps
`define CHECK(nm, ex, ac) begin num_checks++; if ((ac) !== (ex)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, ex, ac); end end
module test_function_enable_power_status;
    import fstat_pkg::*;
    logic         clk_i = 1'b0;
    logic         srst_i = 1'b1;
    logic [7:0]   addr = '0;
    logic [31:0]  wdata = '0;
    logic         wr = 1'b0;
    logic         rd = 1'b0;
    logic [31:0]  rdata;
    logic [31:0]  rdata_dual;
    logic [31:0]  rdata_single;
    logic [31:0]  got [3];
    logic [1:0]   strap = '0;
    logic         nv = 1'b0;
    logic [7:0]   na = '0;
    logic [15:0]  nd = '0;
    logic [1:0]   aux = '0;
    power_state_e ps0 = device_reset_state;
    power_state_e ps1 = device_reset_state;
    logic         s5 = 1'b0;
    int           errors = 0;
    int           num_checks = 0;

    always #2.5 clk_i = ~clk_i;

    function_enable_power_status dut (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .strap_pin_i(strap), .nvm_word_valid_i(nv),
        .nvm_word_addr_i(na), .nvm_word_data_i(nd), .cfg_aux_en_i(aux), .cfg_power_state0_i(ps0),
        .cfg_power_state1_i(ps1), .system_in_s5_i(s5));

    // The other two variants see the same stimulus and are checked against the same model.
    function_enable_power_status #(.VARIANT(VARIANT_DUAL)) dut_dual (.clk_i(clk_i), .srst_i(srst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata_dual),
        .strap_pin_i(strap), .nvm_word_valid_i(nv), .nvm_word_addr_i(na), .nvm_word_data_i(nd),
        .cfg_aux_en_i(aux), .cfg_power_state0_i(ps0), .cfg_power_state1_i(ps1), .system_in_s5_i(s5));

    function_enable_power_status #(.VARIANT(VARIANT_SINGLE)) dut_single (.clk_i(clk_i), .srst_i(srst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata_single),
        .strap_pin_i(strap), .nvm_word_valid_i(nv), .nvm_word_addr_i(na), .nvm_word_data_i(nd),
        .cfg_aux_en_i(aux), .cfg_power_state0_i(ps0), .cfg_power_state1_i(ps1), .system_in_s5_i(s5));

    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic rd_reg(input logic [7:0] a);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        @(posedge clk_i);
        got[0] = rdata;
        got[1] = rdata_dual;
        got[2] = rdata_single;
    endtask : rd_reg

    // One edge passes after the strobe drops, so a following call never sets it twice in one step.
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
        @(posedge clk_i);
    endtask : wr_reg

    task automatic nvm_load(input logic [7:0] a, input logic [15:0] d);
        nv <= 1'b1;
        na <= a;
        nd <= d;
        @(posedge clk_i);
        nv <= 1'b0;
        @(posedge clk_i);
    endtask : nvm_load

    // Reference status built only from the field rules; v is 0 combo, 1 dual, 2 single.
    function automatic logic [31:0] model(input int v, input int st, input int ax, input int p0, input int p1,
                                          input int w10, input int w20);
        logic [31:0] m;
        m = '0;
        m[1:0] = 2'(p0);
        m[3] = ax[0];
        if (v == 0) begin
            m[2] = !w20[11];
            m[4] = !w20[10] && !w20[11];
            m[8] = st[1];
            m[10] = !w10[10] && st[1];
        end else if (v == 1) begin
            m[2] = st[0];
            m[8] = st[1];
        end else begin
            m[2] = 1'b1;
        end
        if (v != 2) begin
            m[7:6] = 2'(p1);
            m[9] = ax[1];
        end
        return m;
    endfunction : model

    function automatic logic [31:0] ctrl_model(input logic s5v, input logic frz);
        logic [31:0] c;
        c = '0;
        c[CTRL_S5_BIT] = s5v;
        c[CTRL_FREEZE_BIT] = frz;
        return c;
    endfunction : ctrl_model

    task automatic check_status(input string nm, input logic [15:0] w10, input logic [15:0] w20);
        rd_reg(STATUS_OFFSET);
        for (int v = 0; v < 3; v++) begin
            `CHECK(nm, model(v, strap, aux, ps0, ps1, w10, w20), got[v])
        end
    endtask : check_status

    task automatic release_reset;
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        rd_reg(STATUS_OFFSET);
        for (int v = 0; v < 3; v++) begin
            `CHECK("status at reset", STATUS_RESET, got[v])
        end
    endtask : release_reset

    initial begin
        logic [15:0] w10;
        logic [15:0] w20;
        logic [15:0] w10f;
        logic [15:0] w20f;
        w10 = 16'($urandom(32'hec4f));
        release_reset();
        repeat (40) begin
            strap <= 2'($urandom);
            aux <= 2'($urandom);
            ps0 <= power_state_e'(2'($urandom));
            ps1 <= power_state_e'(2'($urandom));
            s5 <= 1'($urandom);
            w10 = 16'($urandom);
            w20 = 16'($urandom);
            w10f = w10 ^ (16'h0001 << NVM_BUS_DISABLE_BIT);
            w20f = w20 ^ (16'h0001 << NVM_PORT_DISABLE_BIT);
            nvm_load(NVM_WORD_PORT1, w10);
            nvm_load(NVM_WORD_PORT0, w20);
            repeat (4) @(posedge clk_i);
            check_status("status", w10, w20);
            wr_reg(STATUS_OFFSET, $urandom);
            wr_reg(8'h0c, $urandom);
            check_status("status after write", w10, w20);
            rd_reg(8'h0c);
            `CHECK("unmapped", 32'h0000_0000, got[0])
            rd_reg(CTRL_OFFSET);
            `CHECK("control", ctrl_model(s5, 1'b0), got[0])
            // Frozen, the new memory words must not reach the status until the freeze is lifted.
            wr_reg(CTRL_OFFSET, 32'h0000_0001 << CTRL_FREEZE_BIT);
            nvm_load(NVM_WORD_PORT1, w10f);
            nvm_load(NVM_WORD_PORT0, w20f);
            repeat (4) @(posedge clk_i);
            check_status("frozen status", w10, w20);
            rd_reg(CTRL_OFFSET);
            `CHECK("control frozen", ctrl_model(s5, 1'b1), got[0])
            wr_reg(CTRL_OFFSET, 32'h0000_0000);
            check_status("thawed status", w10f, w20f);
        end
        // A second reset drops both enables again until the memory words reload.
        srst_i <= 1'b1;
        release_reset();
        repeat (4) @(posedge clk_i);
        check_status("status after reset", {16{NVM_DISABLE_RESET}}, {16{NVM_DISABLE_RESET}});
        complete_run();
    end

    // The sequence needs under two thousand cycles; this bound cuts off a hang.
    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        complete_run();
    end
endmodule : test_function_enable_power_status

// [verilog/fstat_pkg.sv]
package fstat_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets (byte addresses).
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 8'h04;

    // Status register field positions.
    localparam int F0_PSTATE_LSB  = 0;
    localparam int F0_PRESENT_BIT = 2;
    localparam int F0_AUX_BIT     = 3;
    localparam int F0_ENABLED_BIT = 4;
    localparam int F1_PSTATE_LSB  = 6;
    localparam int F1_PRESENT_BIT = 8;
    localparam int F1_AUX_BIT     = 9;
    localparam int F1_ENABLED_BIT = 10;

    // Control register field positions.
    localparam int CTRL_FREEZE_BIT = 0;
    localparam int CTRL_S5_BIT     = 1;

    // Non-volatile memory words and bits that feed the status.
    localparam int              NVM_ADDR_W           = 8;
    localparam int              NVM_DATA_W           = 16;
    localparam logic [7:0]      NVM_WORD_PORT1       = 8'h10;
    localparam logic [7:0]      NVM_WORD_PORT0       = 8'h20;
    localparam int              NVM_BUS_DISABLE_BIT  = 10;
    localparam int              NVM_PORT_DISABLE_BIT = 11;

    // Reset values.
    localparam logic [DATA_W-1:0] STATUS_RESET      = 32'h0000_0000;
    localparam logic              FREEZE_RESET      = 1'b0;
    localparam logic              NVM_DISABLE_RESET = 1'b1;

    // Number of strap pins and synchroniser depth.
    localparam int STRAP_N     = 2;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        device_reset_state         = 2'b00,
        active_uninitialised_state = 2'b01,
        active_running_state       = 2'b10,
        low_power_state            = 2'b11
    } power_state_e;

    typedef enum logic [2:0] {
        VARIANT_COMBO  = 3'b001,
        VARIANT_DUAL   = 3'b010,
        VARIANT_SINGLE = 3'b100
    } variant_e;

endpackage : fstat_pkg

// [verilog/function_enable_power_status.sv]
`timescale 1ns/1ps
// Overview of operation
// - Port1 enabled = bus-enable from word 10h AND present (combo variant; 0 in dual and single).
// - Bit 9 shadows function 1 aux enable (combo and dual variants; 0 in single).
// - Bit 8 shows port1 present from second strap (combo and dual variants; 0 in single).
// - Bits 7:6 carry function 1 power state (combo and dual variants; device_reset_state in single).
// - Port0 enabled = bus-enable from word 20h AND present (combo variant; 0 in dual and single).
// - Bit 3 shadows function 0 aux enable.
// - Bit 2 port0 present, source per variant.
// - Bits 1:0 carry function 0 power state.
module function_enable_power_status
    import fstat_pkg::*;
#(
    parameter variant_e VARIANT = VARIANT_COMBO
)
(
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    // Register port
    input  wire logic [ADDR_W-1:0]     reg_addr_i,
    input  wire logic [DATA_W-1:0]     reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [DATA_W-1:0]     reg_rdata_o,
    // Strap pins
    input  wire logic [STRAP_N-1:0]    strap_pin_i,
    // Non-volatile memory word load
    input  wire logic                  nvm_word_valid_i,
    input  wire logic [NVM_ADDR_W-1:0] nvm_word_addr_i,
    input  wire logic [NVM_DATA_W-1:0] nvm_word_data_i,
    // Configuration space shadows
    input  wire logic [1:0]            cfg_aux_en_i,
    input  wire power_state_e          cfg_power_state0_i,
    input  wire power_state_e          cfg_power_state1_i,
    // System sleep indication
    input  wire logic                  system_in_s5_i
);

    strap_if straps ();

    strap_sync u_strap_sync (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .strap_pin_i (strap_pin_i),
        .sync_o      (straps)
    );

    // Latched non-volatile disable bits. They reset to "disabled" so that no port shows
    // enabled before the memory has been read.
    logic nvm_port1_bus_disable;
    logic nvm_port0_bus_disable;
    logic nvm_port_disable;
    logic next_nvm_port1_bus_disable;
    logic next_nvm_port0_bus_disable;
    logic next_nvm_port_disable;

    always_comb begin
        next_nvm_port1_bus_disable = nvm_port1_bus_disable;
        next_nvm_port0_bus_disable = nvm_port0_bus_disable;
        next_nvm_port_disable      = nvm_port_disable;
        if (nvm_word_valid_i && nvm_word_addr_i == NVM_WORD_PORT1) begin
            next_nvm_port1_bus_disable = nvm_word_data_i[NVM_BUS_DISABLE_BIT];
        end
        if (nvm_word_valid_i && nvm_word_addr_i == NVM_WORD_PORT0) begin
            next_nvm_port0_bus_disable = nvm_word_data_i[NVM_BUS_DISABLE_BIT];
            next_nvm_port_disable      = nvm_word_data_i[NVM_PORT_DISABLE_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            nvm_port1_bus_disable <= NVM_DISABLE_RESET;
            nvm_port0_bus_disable <= NVM_DISABLE_RESET;
            nvm_port_disable      <= NVM_DISABLE_RESET;
        end else begin
            nvm_port1_bus_disable <= next_nvm_port1_bus_disable;
            nvm_port0_bus_disable <= next_nvm_port0_bus_disable;
            nvm_port_disable      <= next_nvm_port_disable;
        end
    end

    // Status fields, computed from their sources every cycle.
    logic         lan_port0_present;
    logic         lan_port1_present;
    logic         lan_port0_enabled;
    logic         lan_port1_enabled;
    logic         func1_aux_en;
    power_state_e func1_power_state;

    always_comb begin
        lan_port0_present = 1'b0;
        lan_port1_present = 1'b0;
        lan_port0_enabled = 1'b0;
        lan_port1_enabled = 1'b0;
        func1_aux_en      = cfg_aux_en_i[1];
        func1_power_state = cfg_power_state1_i;
        unique case (VARIANT)
            VARIANT_COMBO: begin
                lan_port0_present = ~nvm_port_disable;
                lan_port1_present = straps.strap[1];
                lan_port0_enabled = ~nvm_port0_bus_disable & lan_port0_present;
                lan_port1_enabled = ~nvm_port1_bus_disable & lan_port1_present;
            end
            VARIANT_DUAL: begin
                lan_port0_present = straps.strap[0];
                lan_port1_present = straps.strap[1];
            end
            VARIANT_SINGLE: begin
                // Single-port parts have no function 1 fields at all.
                lan_port0_present = 1'b1;
                lan_port1_present = 1'b0;
                func1_aux_en      = 1'b0;
                func1_power_state = device_reset_state;
            end
        endcase
    end

    logic [DATA_W-1:0] live_status;

    always_comb begin
        live_status                                     = '0;
        live_status[F0_PSTATE_LSB +: 2]                 = cfg_power_state0_i;
        live_status[F0_PRESENT_BIT]                     = lan_port0_present;
        live_status[F0_AUX_BIT]                         = cfg_aux_en_i[0];
        live_status[F0_ENABLED_BIT]                     = lan_port0_enabled;
        live_status[F1_PSTATE_LSB +: 2]                 = func1_power_state;
        live_status[F1_PRESENT_BIT]                     = lan_port1_present;
        live_status[F1_AUX_BIT]                         = func1_aux_en;
        live_status[F1_ENABLED_BIT]                     = lan_port1_enabled;
    end

    // Address decode shared by the read and write paths.
    logic hit_status;
    logic hit_ctrl;

    always_comb begin
        hit_status = (reg_addr_i == STATUS_OFFSET);
        hit_ctrl   = (reg_addr_i == CTRL_OFFSET);
    end

    // Control register.
    logic freeze;
    logic next_freeze;

    always_comb begin
        next_freeze = freeze;
        if (reg_wr_i && hit_ctrl) begin
            next_freeze = reg_wdata_i[CTRL_FREEZE_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            freeze <= FREEZE_RESET;
        end else begin
            freeze <= next_freeze;
        end
    end

    // Status register.
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] next_status;

    always_comb begin
        // Freeze lets software take a coherent snapshot across several reads.
        // Writes to the status offset fall through and change nothing.
        next_status = freeze ? status : live_status;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            status <= STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    // The sleep indication comes from the system side, off this clock, so it is double flopped.
    logic s5_meta;
    logic s5_seen;
    logic next_s5_meta;
    logic next_s5_seen;

    always_comb begin
        next_s5_meta = system_in_s5_i;
        next_s5_seen = s5_meta;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s5_meta <= 1'b0;
            s5_seen <= 1'b0;
        end else begin
            s5_meta <= next_s5_meta;
            s5_seen <= next_s5_seen;
        end
    end

    // Read port: data one cycle after the strobe, zero otherwise and for unmapped offsets.
    logic [DATA_W-1:0] next_rdata;

    always_comb begin
        next_rdata = '0;
        if (reg_rd_i) begin
            if (hit_status) begin
                next_rdata = status;
            end else if (hit_ctrl) begin
                next_rdata[CTRL_FREEZE_BIT] = freeze;
                // The S5 flag warns firmware that the status fields cannot be trusted.
                next_rdata[CTRL_S5_BIT]     = s5_seen;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

endmodule : function_enable_power_status

// [verilog/strap_if.sv]
`timescale 1ns/1ps
interface strap_if;
    import fstat_pkg::*;

    logic [STRAP_N-1:0] strap;

    modport producer (output strap);
    modport consumer (input  strap);
endinterface : strap_if

// [verilog/strap_sync.sv]
`timescale 1ns/1ps
module strap_sync
    import fstat_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               srst_i,
    // Raw strap pins
    input  wire logic [STRAP_N-1:0] strap_pin_i,
    // Synchronised straps
    strap_if.producer               sync_o
);

    logic [SYNC_STAGES-1:0] stage [STRAP_N];
    logic [SYNC_STAGES-1:0] next_stage [STRAP_N];

    // Straps are quasi-static, but a pin may still move near an edge, so each one is double flopped.
    genvar g;
    generate
        for (g = 0; g < STRAP_N; g++) begin : g_bit
            always_comb begin
                next_stage[g] = {stage[g][SYNC_STAGES-2:0], strap_pin_i[g]};
            end

            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    stage[g] <= '0;
                end else begin
                    stage[g] <= next_stage[g];
                end
            end

            assign sync_o.strap[g] = stage[g][SYNC_STAGES-1];
        end
    endgenerate

endmodule : strap_sync
